// File: src/fhp_pkg.sv
// package for the floppy board host port block
`default_nettype none
package fhp_pkg;
    localparam logic [7:0] FHP_PORT_DRIVE = 8'hF3;
    localparam logic [7:0] FHP_PORT_STATCMD = 8'hF4;
    localparam logic [7:0] FHP_PORT_TRACK = 8'hF5;
    localparam logic [7:0] FHP_PORT_SECTOR = 8'hF6;
    localparam logic [7:0] FHP_PORT_DATA = 8'hF7;
    localparam int FHP_BIT_SIDE = 4;
    localparam int FHP_BIT_MINI = 5;
    localparam int FHP_BIT_SDEN = 6;
    localparam int FHP_BIT_WAIT = 7;
    localparam logic [7:0] FHP_DRIVE_RESET = 8'h00;
    localparam logic [7:0] FHP_VECTOR_DEFAULT = 8'h36;
    localparam logic [7:0] FHP_PRECOMP_TRACK = 8'h2B;
    localparam logic [7:0] FHP_REG_RESET = 8'h00;

    // host bus access, one cycle strobe
    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } fhp_bus_type;

    // pass-through strobes to the formatter chip
    typedef struct packed {
        logic rd;
        logic wr;
        logic [1:0] sel;
        logic [7:0] wdata;
    } fhp_fmt_type;
endpackage : fhp_pkg
`default_nettype wire

// File: src/fhp_sync.sv
// two flip-flop synchroniser for pin inputs
`default_nettype none
module fhp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk, // system clock
    input wire logic rst, // async reset
    input wire logic [WIDTH-1:0] din, // asynchronous pin level
    output logic [WIDTH-1:0] dout // synchronised level
);
    logic [WIDTH-1:0] stage1;

    // first stage feeds only the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            stage1 <= '0;
            dout <= '0;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule : fhp_sync
`default_nettype wire

// File: src/fhp_ports.sv
// host port decoder and drive control register of the floppy board
`default_nettype none
module fhp_ports
    import fhp_pkg::*;
(
    input wire logic clk, // 50 MHz system clock
    input wire logic rst, // async reset, active high
    input wire fhp_bus_type bus, // host I/O access strobes
    output logic [7:0] rdata, // host read data
    output logic rvalid, // read data valid, one cycle
    output logic wait_req, // host wait state request
    output fhp_fmt_type fmt, // strobes to the formatter
    input wire logic [7:0] fmt_rdata, // formatter read data
    input wire logic fmt_busy, // formatter access in progress
    input wire logic fmt_intrq, // formatter interrupt request
    input wire logic pri_in_n, // priority chain input, low grants
    output logic pri_out_n, // priority chain output
    output logic int_req_n, // bus interrupt request
    input wire logic [7:0] vec_jumper_n, // vector jumpers, fitted pulls low
    output logic [7:0] vector, // interrupt vector
    input wire logic size_soft_jmp, // jumper: software size control
    input wire logic size_mini_jmp, // jumper: hardwired 5.25-inch
    input wire logic one_sided_pin, // two-sided sense, high single sided
    output logic drive_zero_select, // drive 0 select
    output logic drive_one_select, // drive 1 select
    output logic drive_two_select, // drive 2 select
    output logic drive_three_select, // drive 3 select
    output logic side_one, // side 1 select
    output logic mini_drive, // 5.25-inch media in use
    output logic double_density_enable_n, // low for double density
    output logic precomp_en // write precompensation enable
);
    typedef struct packed {
        logic [7:0] cmd;
        logic [7:0] rdata;
        logic rvalid;
        logic waiting;
        fhp_fmt_type fmt;
        logic [7:0] track;
        logic [7:0] vector;
        logic int_req_n;
        logic pri_out_n;
        logic mini;
        logic precomp;
    } fhp_state_type;

    fhp_state_type st;
    fhp_state_type next_st;
    logic [5:0] pins_sync;
    logic hit;
    logic [2:0] idx;
    logic [7:0] status_byte;

    // pins arrive from outside the clock domain
    fhp_sync #(.WIDTH(6)) u_sync (
        .clk(clk),
        .rst(rst),
        .din({fmt_intrq, pri_in_n, size_soft_jmp, size_mini_jmp, one_sided_pin, fmt_busy}),
        .dout(pins_sync)
    );

    logic [7:0] vec_sync;
    fhp_sync #(.WIDTH(8)) u_vsync (
        .clk(clk),
        .rst(rst),
        .din(vec_jumper_n),
        .dout(vec_sync)
    );

    // address decode and status byte
    always_comb begin
        hit = (bus.addr >= FHP_PORT_DRIVE) && (bus.addr <= FHP_PORT_DATA);
        idx = 3'(bus.addr - FHP_PORT_DRIVE);
        status_byte = {pins_sync[1], st.cmd[FHP_BIT_SDEN],
                       st.mini, st.cmd[FHP_BIT_SIDE], st.cmd[3:0]};
    end

    // next state
    always_comb begin
        next_st = st;
        next_st.rvalid = 1'b0;
        next_st.fmt.rd = 1'b0;
        next_st.fmt.wr = 1'b0;
        // fitted jumper reads as one
        next_st.vector = ~vec_sync;
        if (bus.wr && hit) begin
            if (idx == 3'd0) begin
                next_st.cmd = bus.wdata;
            end else begin
                next_st.fmt.wr = 1'b1;
                next_st.fmt.sel = 2'(idx - 3'd1);
                next_st.fmt.wdata = bus.wdata;
                if (idx == 3'd2) begin
                    next_st.track = bus.wdata;
                end
            end
        end
        // size follows the new command on the same edge as the select pins
        next_st.mini = pins_sync[3] ? next_st.cmd[FHP_BIT_MINI] : pins_sync[2];
        if (bus.rd && hit) begin
            next_st.rvalid = 1'b1;
            if (idx == 3'd0) begin
                next_st.rdata = status_byte;
            end else begin
                next_st.fmt.rd = 1'b1;
                next_st.fmt.sel = 2'(idx - 3'd1);
                next_st.rdata = fmt_rdata;
            end
        end
        // wait states only on formatter ports and only when enabled
        next_st.waiting = st.cmd[FHP_BIT_WAIT] && hit && (bus.rd || bus.wr)
                          && (idx != 3'd0) && pins_sync[0];
        // request only while the chain input grants (low), otherwise pass the grant on
        next_st.int_req_n = ~(pins_sync[5] && ~pins_sync[4]);
        next_st.pri_out_n = pins_sync[4] | pins_sync[5];
        next_st.precomp = ~st.cmd[FHP_BIT_SDEN] && (st.track > FHP_PRECOMP_TRACK);
    end

    // state register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.cmd <= FHP_DRIVE_RESET;
            st.int_req_n <= 1'b1;
            st.pri_out_n <= 1'b1;
            st.vector <= FHP_VECTOR_DEFAULT;
            st.track <= FHP_REG_RESET;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from state flip-flops
    assign rdata = st.rdata;
    assign rvalid = st.rvalid;
    assign wait_req = st.waiting;
    assign fmt = st.fmt;
    assign pri_out_n = st.pri_out_n;
    assign int_req_n = st.int_req_n;
    assign vector = st.vector;
    assign drive_zero_select = st.cmd[0];
    assign drive_one_select = st.cmd[1];
    assign drive_two_select = st.cmd[2];
    assign drive_three_select = st.cmd[3];
    assign side_one = st.cmd[FHP_BIT_SIDE];
    assign mini_drive = st.mini;
    assign double_density_enable_n = st.cmd[FHP_BIT_SDEN];
    assign precomp_en = st.precomp;

    // assertions
    chk_cmd_latch: assert property (@(posedge clk) disable iff (rst)
        bus.wr && bus.addr == FHP_PORT_DRIVE |=> st.cmd == $past(bus.wdata))
        else $error("drive command not latched");
    chk_cmd_hold: assert property (@(posedge clk) disable iff (rst)
        !(bus.wr && bus.addr == FHP_PORT_DRIVE) |=> $stable(st.cmd))
        else $error("drive command changed without write");
    chk_out_range: assert property (@(posedge clk) disable iff (rst)
        (bus.rd || bus.wr) && !hit |=> !rvalid && !fmt.rd && !fmt.wr)
        else $error("access outside range answered");
    chk_fmt_strobe: assert property (@(posedge clk) disable iff (rst)
        bus.wr && bus.addr == FHP_PORT_DATA |=> fmt.wr && fmt.sel == 2'd3)
        else $error("data port write not passed");
    chk_stat_strobe: assert property (@(posedge clk) disable iff (rst)
        bus.rd && bus.addr == FHP_PORT_STATCMD |=> fmt.rd && fmt.sel == 2'd0)
        else $error("status read not passed");
    chk_sel_pins: assert property (@(posedge clk) disable iff (rst)
        {drive_three_select, drive_two_select, drive_one_select,
         drive_zero_select} == st.cmd[3:0])
        else $error("select pins differ from command");
    chk_density_pin: assert property (@(posedge clk) disable iff (rst)
        bus.wr && bus.addr == FHP_PORT_DRIVE |=> double_density_enable_n == $past(bus.wdata[FHP_BIT_SDEN]))
        else $error("density pin wrong");
    chk_status_read: assert property (@(posedge clk) disable iff (rst)
        bus.rd && bus.addr == FHP_PORT_DRIVE |=> rvalid
        && rdata[4:0] == $past(st.cmd[4:0]))
        else $error("drive status wrong");
    chk_precomp_sd: assert property (@(posedge clk) disable iff (rst)
        st.cmd[FHP_BIT_SDEN] |=> !precomp_en)
        else $error("precomp in single density");
    chk_wait_off: assert property (@(posedge clk) disable iff (rst)
        !st.cmd[FHP_BIT_WAIT] |=> !wait_req)
        else $error("wait state while disabled");

    // named steps of a host access, shared by the checks below
    sequence s_drive_wr;
        bus.wr && bus.addr == FHP_PORT_DRIVE;
    endsequence
    sequence s_drive_rd;
        bus.rd && bus.addr == FHP_PORT_DRIVE;
    endsequence
    sequence s_fmt_wr;
        bus.wr && hit && idx != 3'd0;
    endsequence
    sequence s_fmt_rd;
        bus.rd && hit && idx != 3'd0;
    endsequence
    sequence s_track_wr;
        bus.wr && bus.addr == FHP_PORT_TRACK;
    endsequence

    // drive command fields land one edge after the write
    chk_select_load: assert property (@(posedge clk) disable iff (rst)
        s_drive_wr |=> st.cmd[3:0] == $past(bus.wdata[3:0]))
        else $error("drive selects not loaded");
    chk_side_pin: assert property (@(posedge clk) disable iff (rst)
        s_drive_wr |=> side_one == $past(bus.wdata[FHP_BIT_SIDE]))
        else $error("side pin not loaded");
    chk_wait_bit: assert property (@(posedge clk) disable iff (rst)
        s_drive_wr |=> st.cmd[FHP_BIT_WAIT] == $past(bus.wdata[FHP_BIT_WAIT]))
        else $error("wait enable not loaded");
    chk_cmd_other: assert property (@(posedge clk) disable iff (rst)
        s_fmt_wr |=> $stable(st.cmd))
        else $error("drive command hit by formatter write");

    // drive status read
    chk_drive_rd_quiet: assert property (@(posedge clk) disable iff (rst)
        s_drive_rd |=> rvalid && !fmt.rd)
        else $error("status read reached formatter");
    chk_status_hi: assert property (@(posedge clk) disable iff (rst)
        s_drive_rd |=> rdata[6] == $past(st.cmd[FHP_BIT_SDEN]) && rdata[5] == $past(st.mini))
        else $error("status size or density wrong");
    chk_status_sense: assert property (@(posedge clk) disable iff (rst)
        s_drive_rd |=> rdata[7] == $past(pins_sync[1]))
        else $error("status sense bit wrong");
    chk_rdata_hold: assert property (@(posedge clk) disable iff (rst)
        !(bus.rd && hit) |=> $stable(rdata))
        else $error("read data moved without read");

    // nothing answers outside the decoded range
    chk_rvalid_pulse: assert property (@(posedge clk) disable iff (rst)
        !(bus.rd && hit) |=> !rvalid)
        else $error("read valid without read");
    chk_fmt_wr_only: assert property (@(posedge clk) disable iff (rst)
        !(bus.wr && hit) |=> !fmt.wr)
        else $error("formatter write without host write");
    chk_fmt_rd_only: assert property (@(posedge clk) disable iff (rst)
        !(bus.rd && hit) |=> !fmt.rd)
        else $error("formatter read without host read");
    chk_drive_no_fmt: assert property (@(posedge clk) disable iff (rst)
        s_drive_wr |=> !fmt.wr && !fmt.rd)
        else $error("drive write reached formatter");

    // formatter ports pass straight through
    chk_fmt_wr_pass: assert property (@(posedge clk) disable iff (rst)
        s_fmt_wr |=> fmt.wr && fmt.wdata == $past(bus.wdata))
        else $error("formatter write data wrong");
    chk_fmt_wr_sel: assert property (@(posedge clk) disable iff (rst)
        s_fmt_wr |=> fmt.sel == $past(bus.addr[1:0]))
        else $error("formatter write select wrong");
    chk_fmt_rd_pass: assert property (@(posedge clk) disable iff (rst)
        s_fmt_rd |=> fmt.rd && rvalid && rdata == $past(fmt_rdata))
        else $error("formatter read data wrong");
    chk_fmt_rd_sel: assert property (@(posedge clk) disable iff (rst)
        s_fmt_rd |=> fmt.sel == $past(bus.addr[1:0]))
        else $error("formatter read select wrong");
    chk_fmt_sel_hold: assert property (@(posedge clk) disable iff (rst)
        !(bus.wr && hit) && !(bus.rd && hit) |=> $stable(fmt.sel))
        else $error("formatter select moved while idle");
    chk_fmt_wdata_hold: assert property (@(posedge clk) disable iff (rst)
        !(bus.wr && hit) |=> $stable(fmt.wdata))
        else $error("formatter data moved while idle");
    chk_track_sel: assert property (@(posedge clk) disable iff (rst)
        s_track_wr |=> fmt.wr && fmt.sel == 2'd1)
        else $error("track write not passed");
    chk_sector_sel: assert property (@(posedge clk) disable iff (rst)
        bus.wr && bus.addr == FHP_PORT_SECTOR |=> fmt.wr && fmt.sel == 2'd2)
        else $error("sector write not passed");
    chk_cmd_sel: assert property (@(posedge clk) disable iff (rst)
        bus.wr && bus.addr == FHP_PORT_STATCMD |=> fmt.wr && fmt.sel == 2'd0)
        else $error("formatter command not passed");
    chk_data_rd_sel: assert property (@(posedge clk) disable iff (rst)
        bus.rd && bus.addr == FHP_PORT_DATA |=> fmt.rd && fmt.sel == 2'd3)
        else $error("data read not passed");

    // track shadow and precompensation
    chk_track_shadow: assert property (@(posedge clk) disable iff (rst)
        s_track_wr |=> st.track == $past(bus.wdata))
        else $error("track shadow not loaded");
    chk_track_hold: assert property (@(posedge clk) disable iff (rst)
        !(bus.wr && bus.addr == FHP_PORT_TRACK) |=> $stable(st.track))
        else $error("track shadow moved");
    chk_precomp_low: assert property (@(posedge clk) disable iff (rst)
        st.track <= FHP_PRECOMP_TRACK |=> !precomp_en)
        else $error("precomp on inner track limit");
    chk_precomp_high: assert property (@(posedge clk) disable iff (rst)
        !st.cmd[FHP_BIT_SDEN] && st.track > FHP_PRECOMP_TRACK |=> precomp_en)
        else $error("precomp missing on outer track");

    // wait states follow enable and formatter busy
    chk_wait_idle: assert property (@(posedge clk) disable iff (rst)
        !pins_sync[0] |=> !wait_req)
        else $error("wait state while formatter idle");
    chk_wait_on: assert property (@(posedge clk) disable iff (rst)
        s_fmt_wr ##0 (st.cmd[FHP_BIT_WAIT] && pins_sync[0]) |=> wait_req)
        else $error("wait state missing");
    chk_drive_no_wait: assert property (@(posedge clk) disable iff (rst)
        s_drive_wr |=> !wait_req)
        else $error("wait state on drive port");

    // interrupt request and priority chain
    chk_int_grant: assert property (@(posedge clk) disable iff (rst)
        pins_sync[5] && !pins_sync[4] |=> !int_req_n)
        else $error("granted interrupt not raised");
    chk_int_idle: assert property (@(posedge clk) disable iff (rst)
        !pins_sync[5] |=> int_req_n)
        else $error("interrupt without formatter request");
    chk_chain_pass: assert property (@(posedge clk) disable iff (rst)
        pins_sync[4] |=> pri_out_n)
        else $error("grant passed without input grant");
    chk_chain_low: assert property (@(posedge clk) disable iff (rst)
        !pins_sync[4] && !pins_sync[5] |=> !pri_out_n)
        else $error("grant not passed on");

    // jumpers: vector and media size source
    chk_vector_jumpers: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> vector == ~$past(vec_sync))
        else $error("vector differs from jumpers");
    chk_size_hard: assert property (@(posedge clk) disable iff (rst)
        !pins_sync[3] |=> mini_drive == $past(pins_sync[2]))
        else $error("hardwired size not used");
    chk_size_soft: assert property (@(posedge clk) disable iff (rst)
        pins_sync[3] && !(bus.wr && bus.addr == FHP_PORT_DRIVE) |=> mini_drive == $past(st.cmd[FHP_BIT_MINI]))
        else $error("software size not used");
    chk_size_soft_wr: assert property (@(posedge clk) disable iff (rst)
        s_drive_wr ##0 pins_sync[3] |=> mini_drive == $past(bus.wdata[FHP_BIT_MINI]))
        else $error("size bit not applied with write");
endmodule : fhp_ports
`default_nettype wire

// File: testbench/fhp_fmt_model.sv
// behavioural formatter register model at the far side of the ports
`default_nettype none
module fhp_fmt_model
    import fhp_pkg::*;
#(
    parameter logic [7:0] STAT = 8'h24 // fixed status byte
) (
    input wire logic clk, // system clock
    input wire fhp_fmt_type fmt, // strobes from the ports
    input wire fhp_bus_type bus, // live host request, read address
    output logic [7:0] fmt_rdata // read data back to the ports
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] regs [4];
    logic [7:0] junk = 8'h5A;
    // writes land on the edge after the strobe; slot 0 is the command
    always @(posedge clk) begin
        junk <= ~junk;
        if (fmt.wr) regs[fmt.sel] <= fmt.wdata;
    end
    // idle bus shows a toggling pattern so stale data never passes
    always_comb begin
        if (bus.rd && bus.addr inside {[8'hF4:8'hF7]})
            fmt_rdata = (bus.addr == 8'hF4) ? STAT : regs[bus.addr[1:0]];
        else
            fmt_rdata = junk;
    end
endmodule : fhp_fmt_model
`default_nettype wire

// File: testbench/floppy_board_host_ports_bench.sv
// self-checking bench for the floppy board host ports
`default_nettype none
module floppy_board_host_ports_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import fhp_pkg::*;
    typedef struct packed {logic wr; logic [7:0] addr; logic [7:0] data; logic [7:0] exp;} fhp_row_type;
    logic clk, rst, rvalid, wait_req, fmt_busy, fmt_intrq, pri_in_n, pri_out_n, int_req_n;
    logic size_soft_jmp, size_mini_jmp, one_sided_pin, precomp_en, side_one, mini_drive;
    logic drive_zero_select, drive_one_select, drive_two_select, drive_three_select;
    logic double_density_enable_n;
    logic [7:0] rdata, fmt_rdata, vec_jumper_n, vector;
    logic [6:0] drv;
    fhp_bus_type bus;
    fhp_fmt_type fmt;
    int fails = 0;
    int total_checks = 0;
    fhp_row_type rows [14] = '{'{1, 8'hF3, 8'h11, 8'h11}, '{0, 8'hF3, 8'h00, 8'h11},
        '{1, 8'hF3, 8'h6A, 8'h6A}, '{0, 8'hF3, 8'h00, 8'h6A}, '{1, 8'hF5, 8'h2C, 8'h2C},
        '{0, 8'hF5, 8'h00, 8'h2C}, '{1, 8'hF6, 8'h5A, 8'h5A}, '{0, 8'hF6, 8'h00, 8'h5A},
        '{1, 8'hF7, 8'hA5, 8'hA5}, '{0, 8'hF7, 8'h00, 8'hA5}, '{1, 8'hF4, 8'h0F, 8'h0F},
        '{0, 8'hF4, 8'h00, 8'h24}, '{0, 8'hF2, 8'h00, 8'h00}, '{1, 8'hF8, 8'h33, 8'h00}};
    assign drv = {double_density_enable_n, mini_drive, side_one, drive_three_select,
        drive_two_select, drive_one_select, drive_zero_select};
    fhp_ports i_dut (.clk, .rst, .bus, .rdata, .rvalid, .wait_req, .fmt, .fmt_rdata, .fmt_busy,
        .fmt_intrq, .pri_in_n, .pri_out_n, .int_req_n, .vec_jumper_n, .vector, .size_soft_jmp,
        .size_mini_jmp, .one_sided_pin, .drive_zero_select, .drive_one_select,
        .drive_two_select, .drive_three_select, .side_one, .mini_drive,
        .double_density_enable_n, .precomp_en);
    fhp_fmt_model i_fmt (.clk, .fmt, .bus, .fmt_rdata);
    // free running 50 MHz clock
    always #10 clk = ~clk;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // one-cycle strobe; checks run after the answering edge has landed
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk);
        #2 bus = '{rd: !wr, wr: wr, addr: addr, wdata: data};
        @(posedge clk);
        #2 bus.rd = 1'b0;
        bus.wr = 1'b0;
    endtask : access
    // pins pass a two-stage synchroniser, so allow several edges
    task automatic settle();
        repeat (4) @(posedge clk);
        #2;
    endtask : settle
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    initial begin
        fhp_row_type r;
        logic inr;
        {clk, fmt_busy, fmt_intrq, size_mini_jmp, one_sided_pin} = '0;
        {rst, pri_in_n, size_soft_jmp} = '1;
        bus = '0;
        vec_jumper_n = ~8'h36;
        repeat (5) @(posedge clk);
        #2 rst = 1'b0;
        chk({1'b0, drv}, 8'h00);
        chk(int_req_n, 1'b1);
        foreach (rows[i]) begin
            r = rows[i];
            inr = r.addr inside {[8'hF4:8'hF7]};
            access(r.wr, r.addr, r.data);
            chk(rvalid, !r.wr && r.addr inside {[8'hF3:8'hF7]});
            chk(fmt.wr, r.wr && inr);
            chk(fmt.rd, !r.wr && inr);
            if (!r.wr && r.addr inside {[8'hF3:8'hF7]}) chk(rdata, r.exp);
            else if (r.wr && r.addr == 8'hF3) chk({1'b0, drv}, r.exp);
            else if (inr) chk({fmt.sel, fmt.wdata}, {r.addr[1:0], r.exp});
        end
        access(1, 8'hF3, 8'h00);
        access(1, 8'hF5, 8'h2B);
        settle();
        chk(precomp_en, 1'b0);
        access(1, 8'hF5, 8'h2C);
        settle();
        chk(precomp_en, 1'b1);
        access(1, 8'hF3, 8'h40);
        settle();
        chk(precomp_en, 1'b0);
        access(1, 8'hF3, 8'h80);
        fmt_busy = 1'b1;
        settle();
        access(1, 8'hF6, 8'h01);
        chk(wait_req, 1'b1);
        access(1, 8'hF3, 8'h00);
        access(1, 8'hF6, 8'h02);
        chk(wait_req, 1'b0);
        fmt_intrq = 1'b1;
        pri_in_n = 1'b0;
        settle();
        chk({int_req_n, pri_out_n}, 2'b01);
        pri_in_n = 1'b1;
        settle();
        chk({int_req_n, pri_out_n}, 2'b11);
        fmt_intrq = 1'b0;
        pri_in_n = 1'b0;
        settle();
        chk(pri_out_n, 1'b0);
        chk(vector, 8'h36);
        vec_jumper_n = ~8'h5C;
        settle();
        chk(vector, 8'h5C);
        {size_soft_jmp, size_mini_jmp, one_sided_pin} = 3'b011;
        settle();
        chk(mini_drive, 1'b1);
        access(0, 8'hF3, 8'h00);
        chk(rdata, 8'hA0);
        size_mini_jmp = 1'b0;
        settle();
        chk(mini_drive, 1'b0);
        access(1, 8'hF3, 8'h1F);
        rst = 1'b1;
        #2 chk({1'b0, drv}, 8'h00);
        summarize();
    end
endmodule : floppy_board_host_ports_bench
`default_nettype wire
